// [src/timer_two_pkg.sv]
// package for the 16-bit capture / reload / baud timer
// assumes a byte-wide special-register port with byte offsets as below
package timer_two_pkg;
  // register offsets
  localparam logic [7:0] ADDR_CONTROL = 8'hC8;
  localparam logic [7:0] ADDR_MODE = 8'hC9;
  localparam logic [7:0] ADDR_RELOAD_LOW = 8'hCA;
  localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hCB;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'hCC;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'hCD;
  // control register bit positions
  localparam int BIT_OVF = 7;
  localparam int BIT_EXF = 6;
  localparam int BIT_RXSEL = 5;
  localparam int BIT_TXSEL = 4;
  localparam int BIT_EXEN = 3;
  localparam int BIT_RUN = 2;
  localparam int BIT_CTSEL = 1;
  localparam int BIT_CPRL = 0;
  // mode register bit position
  localparam int BIT_DOWN_COUNT_ENABLE = 0;
  // reset values
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [15:0] COUNT_ALL_ONES = 16'hFFFF;
  // baud generator advances once per this many clocks
  localparam int BAUD_DIV = 2;
  // software access bundle
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
  // baud time-base outputs
  typedef struct packed {
    logic rx_tick;
    logic tx_tick;
  } baud_out_t;
endpackage

// [src/timer_two.sv]
// 16-bit timer/counter: capture, auto-reload up/down, baud generator
// assumes all inputs synchronous to ref_clk_i; register port answers a
// read in the next cycle; events on event_i are pre-synchronised pulses
//
// Strobed register access was decided locally.
`timescale 1ns/1ns
`default_nettype none
module timer_two (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic clk_en_i,
  input wire timer_two_pkg::reg_req_t req_i,
  output logic [7:0] rdata_o,
  input wire logic trigger_pin_i,
  input wire logic event_i,
  input wire logic timer1_ovf_i,
  output timer_two_pkg::baud_out_t baud_o,
  output logic ovf_flag_o,
  output logic ext_flag_o,
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////
  // registers and decode
  logic [7:0] control_reg;
  logic [7:0] mode_reg;
  logic [7:0] reload_low_reg;
  logic [7:0] reload_high_reg;
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic trig_q_reg;
  logic baud_div_reg;
  logic [7:0] rdata_next;

  logic wr_ctl, wr_mode, wr_rl, wr_rh, wr_cl, wr_ch;
  assign wr_ctl = req_i.wr && (req_i.addr == timer_two_pkg::ADDR_CONTROL);
  assign wr_mode = req_i.wr && (req_i.addr == timer_two_pkg::ADDR_MODE);
  assign wr_rl = req_i.wr && (req_i.addr == timer_two_pkg::ADDR_RELOAD_LOW);
  assign wr_rh = req_i.wr && (req_i.addr == timer_two_pkg::ADDR_RELOAD_HIGH);
  assign wr_cl = req_i.wr && (req_i.addr == timer_two_pkg::ADDR_COUNT_LOW);
  assign wr_ch = req_i.wr && (req_i.addr == timer_two_pkg::ADDR_COUNT_HIGH);

  // control fields
  logic rxsel, txsel, exen, run, ctsel, cprl, down_count_enable, baud_mode;
  assign rxsel = control_reg[timer_two_pkg::BIT_RXSEL];
  assign txsel = control_reg[timer_two_pkg::BIT_TXSEL];
  assign exen = control_reg[timer_two_pkg::BIT_EXEN];
  assign run = control_reg[timer_two_pkg::BIT_RUN];
  assign ctsel = control_reg[timer_two_pkg::BIT_CTSEL];
  assign cprl = control_reg[timer_two_pkg::BIT_CPRL];
  assign down_count_enable = mode_reg[timer_two_pkg::BIT_DOWN_COUNT_ENABLE];
  assign baud_mode = rxsel | txsel;

  ////////////////////////////////////////////////////////////////////////
  // trigger edge and tick generation
  logic fall;
  assign fall = trig_q_reg && !trigger_pin_i;

  // previous pin sample for edge detection
  // resets low, so a pin already low at release is no edge
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      trig_q_reg <= 1'b0;
    end else if (clk_en_i) begin
      trig_q_reg <= trigger_pin_i;
    end
  end

  // baud divider: free-running while in baud mode and running
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      baud_div_reg <= 1'b0;
    end else if (clk_en_i) begin
      if (baud_mode && run) begin
        baud_div_reg <= !baud_div_reg;
      end else begin
        baud_div_reg <= 1'b0;
      end
    end
  end

  logic tick;
  always_comb begin
    if (!run) begin
      tick = 1'b0;
    end else if (baud_mode) begin
      tick = baud_div_reg;
    end else if (ctsel) begin
      tick = event_i;
    end else begin
      tick = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // counting, overflow, reload
  logic down, ovf, trig_act, reload_trig, capture_trig;
  logic [15:0] reload_val;
  assign reload_val = {reload_high_reg, reload_low_reg};
  // down counting only in reload mode, outside baud mode
  assign down = down_count_enable && !cprl && !baud_mode && trigger_pin_i;
  assign trig_act = fall && exen && !baud_mode;
  // with down count enabled the pin sets direction, not reloads
  assign reload_trig = trig_act && !cprl && !down_count_enable;
  assign capture_trig = trig_act && cprl;

  always_comb begin
    ovf = 1'b0;
    if (tick) begin
      if (down) begin
        ovf = (count_reg == reload_val);
      end else begin
        ovf = (count_reg == timer_two_pkg::COUNT_ALL_ONES);
      end
    end
  end

  // counter byte writes beat reload and tick in the same cycle
  always_comb begin
    count_next = count_reg;
    if (wr_cl) begin
      count_next[7:0] = req_i.wdata;
    end else if (wr_ch) begin
      count_next[15:8] = req_i.wdata;
    end else if (reload_trig) begin
      count_next = reload_val;
    end else if (tick) begin
      if (down) begin
        count_next = ovf ? timer_two_pkg::COUNT_ALL_ONES : count_reg - 16'h0001;
      end else if (ovf && (baud_mode || !cprl)) begin
        count_next = reload_val;
      end else begin
        count_next = count_reg + 16'h0001;
      end
    end
  end

  // counter bytes
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count_reg <= timer_two_pkg::RST_COUNT;
    end else if (clk_en_i) begin
      count_reg <= count_next;
    end
  end

  // capture/reload bytes; capture wins over a same-cycle write
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reload_low_reg <= timer_two_pkg::RST_BYTE;
      reload_high_reg <= timer_two_pkg::RST_BYTE;
    end else if (clk_en_i) begin
      if (capture_trig) begin
        reload_low_reg <= count_reg[7:0];
        reload_high_reg <= count_reg[15:8];
      end else begin
        if (wr_rl) begin
          reload_low_reg <= req_i.wdata;
        end
        if (wr_rh) begin
          reload_high_reg <= req_i.wdata;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control register and flags; hardware set wins over software clear
  logic set_ovf, set_exf;
  assign set_ovf = ovf && !baud_mode;
  // external flag: trigger in capture, or in reload with down count off, or down-count overflow
  assign set_exf = (trig_act && !down_count_enable) || (trig_act && cprl)
                   || (ovf && down);

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      control_reg <= timer_two_pkg::RST_CONTROL;
    end else if (clk_en_i) begin
      if (wr_ctl) begin
        control_reg <= req_i.wdata;
      end
      if (set_ovf) begin
        control_reg[timer_two_pkg::BIT_OVF] <= 1'b1;
      end
      if (set_exf) begin
        control_reg[timer_two_pkg::BIT_EXF] <= 1'b1;
      end
    end
  end

  // mode register: only the down-count bit is kept
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_reg <= timer_two_pkg::RST_MODE;
    end else if (clk_en_i && wr_mode) begin
      mode_reg <= {7'h00, req_i.wdata[timer_two_pkg::BIT_DOWN_COUNT_ENABLE]};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read port, one cycle latency
  // unmapped addresses and idle cycles read as zero
  always_comb begin
    case (req_i.addr)
      timer_two_pkg::ADDR_CONTROL: rdata_next = control_reg;
      timer_two_pkg::ADDR_MODE: rdata_next = mode_reg;
      timer_two_pkg::ADDR_RELOAD_LOW: rdata_next = reload_low_reg;
      timer_two_pkg::ADDR_RELOAD_HIGH: rdata_next = reload_high_reg;
      timer_two_pkg::ADDR_COUNT_LOW: rdata_next = count_reg[7:0];
      timer_two_pkg::ADDR_COUNT_HIGH: rdata_next = count_reg[15:8];
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= 8'h00;
    end else if (clk_en_i) begin
      rdata_o <= req_i.rd ? rdata_next : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // baud and flag outputs, registered
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      baud_o <= '0;
      ovf_flag_o <= 1'b0;
      ext_flag_o <= 1'b0;
      irq_o <= 1'b0;
    end else if (clk_en_i) begin
      baud_o.rx_tick <= rxsel ? ovf : timer1_ovf_i;
      baud_o.tx_tick <= txsel ? ovf : timer1_ovf_i;
      ovf_flag_o <= control_reg[timer_two_pkg::BIT_OVF];
      ext_flag_o <= control_reg[timer_two_pkg::BIT_EXF];
      irq_o <= control_reg[timer_two_pkg::BIT_OVF]
               | control_reg[timer_two_pkg::BIT_EXF];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  reload_on_ovf_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    clk_en_i && tick && ovf && !down && (baud_mode || !cprl) && !wr_cl && !wr_ch
    && !reload_trig |=> count_reg == $past(reload_val))
    else $error("reload on overflow missed");
  ovf_flag_set_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    clk_en_i && set_ovf |=> control_reg[timer_two_pkg::BIT_OVF])
    else $error("overflow flag not set");
  baud_no_flag_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    clk_en_i && baud_mode && !wr_ctl && !control_reg[timer_two_pkg::BIT_OVF]
    |=> !control_reg[timer_two_pkg::BIT_OVF])
    else $error("overflow flag set in baud mode");
  flag_sticky_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    control_reg[timer_two_pkg::BIT_OVF] && !wr_ctl |=>
    control_reg[timer_two_pkg::BIT_OVF])
    else $error("overflow flag cleared by hardware");
  halt_keeps_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    !run && !wr_cl && !wr_ch && !reload_trig |=> $stable(count_reg))
    else $error("count moved while halted");
  capture_copy_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    clk_en_i && capture_trig |=> {reload_high_reg, reload_low_reg} == $past(count_reg))
    else $error("capture mismatch");
  trig_ignored_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    clk_en_i && !exen && !wr_rl && !wr_rh
    |=> $stable({reload_high_reg, reload_low_reg}))
    else $error("trigger acted while disabled");
  // a reload value of all ones would hold the count still; left out
  sequence baud_two_s;
    clk_en_i && baud_mode && run && !wr_cl && !wr_ch
    && reload_val != timer_two_pkg::COUNT_ALL_ONES ##1
    clk_en_i && baud_mode && run && !wr_cl && !wr_ch
    && reload_val != timer_two_pkg::COUNT_ALL_ONES;
  endsequence
  baud_rate_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    baud_two_s |=> count_reg != $past(count_reg, 2))
    else $error("baud counter did not advance in two clocks");

  ////////////////////////////////////////////////////////////////////////
  // edge, reload, flag and direction checks
  // the write strobes to the counter bytes override everything else, so
  // each counting check below leaves those cycles out
  logic count_free;
  assign count_free = clk_en_i && !wr_cl && !wr_ch;

  // one high sample of the pin followed by one low sample
  sequence pin_fall_s;
    clk_en_i && trigger_pin_i ##1 clk_en_i && !trigger_pin_i;
  endsequence

  edge_detect_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    pin_fall_s |-> fall)
    else $error("falling edge on the pin not seen");
  pin_reload_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    pin_fall_s ##0 (count_free && exen && !cprl && !down_count_enable && !baud_mode)
    |=> count_reg == $past(reload_val))
    else $error("pin edge did not reload the count");
  ext_pin_flag_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    pin_fall_s ##0 (exen && !baud_mode && (cprl || !down_count_enable))
    |=> control_reg[timer_two_pkg::BIT_EXF])
    else $error("pin edge did not set the external flag");
  ext_sticky_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    control_reg[timer_two_pkg::BIT_EXF] && !wr_ctl
    |=> control_reg[timer_two_pkg::BIT_EXF])
    else $error("external flag cleared by hardware");
  irq_level_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    clk_en_i && control_reg[timer_two_pkg::BIT_EXF] |=> irq_o)
    else $error("interrupt request missing for external flag");

  // down count: a match loads all ones and raises both flags; any other
  // tick steps down by one
  down_match_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    count_free && tick && down && count_reg == reload_val
    |=> count_reg == timer_two_pkg::COUNT_ALL_ONES
    && control_reg[timer_two_pkg::BIT_OVF])
    else $error("down-count match did not load all ones and flag");
  down_ext_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    count_free && tick && down && count_reg == reload_val
    |=> control_reg[timer_two_pkg::BIT_EXF])
    else $error("down-count match did not set the external flag");
  down_step_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    count_free && tick && down && count_reg != reload_val
    |=> count_reg == $past(count_reg) - 16'h0001)
    else $error("down count did not step by one");
  up_step_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    count_free && tick && !down && !ovf && !reload_trig
    |=> count_reg == $past(count_reg) + 16'h0001)
    else $error("up count did not step by one");
  event_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    count_free && run && ctsel && !baud_mode && !event_i && !reload_trig
    |=> $stable(count_reg))
    else $error("counter moved without an event");

  ////////////////////////////////////////////////////////////////////////
  // baud outputs, read port and clock enable checks
  rx_other_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    clk_en_i && !rxsel && timer1_ovf_i |=> baud_o.rx_tick)
    else $error("receive tick lost the other timer overflow");
  tx_own_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    clk_en_i && txsel && !ovf |=> !baud_o.tx_tick)
    else $error("transmit tick without own overflow");
  read_count_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    clk_en_i && req_i.rd && req_i.addr == timer_two_pkg::ADDR_COUNT_LOW
    |=> rdata_o == $past(count_reg[7:0]))
    else $error("counter low byte read wrong");
  // a held enable must freeze counting, flags and the read port alike
  enable_freeze_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    !clk_en_i |=> $stable(count_reg) && $stable(control_reg) && $stable(rdata_o))
    else $error("state moved while the clock enable was low");

endmodule
`default_nettype wire

// [bench/baud_partner.sv]
// far side of the timer: the other timer's overflow source and a serial
// baud consumer that counts the receive and transmit ticks it is handed
`timescale 1ns/1ns
`default_nettype none
module baud_partner (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire timer_two_pkg::baud_out_t baud_i,
  input wire logic clr_i,
  output logic timer1_ovf_o,
  output logic [15:0] rx_count_o,
  output logic [15:0] tx_count_o
);
  logic [2:0] div_reg;
  ////////////////////////////////////////////////////////////////////////
  // other timer overflows once per 8 clocks, free running
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_reg <= 3'h0;
      timer1_ovf_o <= 1'b0;
    end else begin
      div_reg <= div_reg + 3'h1;
      timer1_ovf_o <= (div_reg == 3'h7);
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // ticks are one-cycle pulses, so one count per high sample
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_count_o <= 16'h0000;
      tx_count_o <= 16'h0000;
    end else if (clr_i) begin
      rx_count_o <= 16'h0000;
      tx_count_o <= 16'h0000;
    end else begin
      rx_count_o <= rx_count_o + {15'h0000, baud_i.rx_tick};
      tx_count_o <= tx_count_o + {15'h0000, baud_i.tx_tick};
    end
  end
endmodule
`default_nettype wire

// [bench/test_timer_two.sv]
// self-checking bench for the capture / reload / baud timer
// assumes the partner model beside it and a free 125 MHz clock
`timescale 1ns/1ns
`default_nettype none
module test_timer_two;
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  timer_two_pkg::reg_req_t req = '0;
  logic pin = 1'b1;
  logic evt = 1'b0;
  logic cen = 1'b1;
  logic clr = 1'b0;
  logic t1_ovf;
  logic [7:0] rdata;
  timer_two_pkg::baud_out_t baud;
  logic ovf_flag, ext_flag, irq;
  logic [15:0] rx_n, tx_n;
  logic [7:0] keep;
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  always #4 ref_clk_i = ~ref_clk_i;
  timer_two timer_two_inst (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .clk_en_i(cen),
    .req_i(req), .rdata_o(rdata), .trigger_pin_i(pin), .event_i(evt),
    .timer1_ovf_i(t1_ovf), .baud_o(baud), .ovf_flag_o(ovf_flag),
    .ext_flag_o(ext_flag), .irq_o(irq));
  baud_partner baud_partner_inst (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .baud_i(baud),
    .clr_i(clr), .timer1_ovf_o(t1_ovf), .rx_count_o(rx_n), .tx_count_o(tx_n));
  ////////////////////////////////////////////////////////////////////////
  // compare, verdict and hang guard
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic close_out();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ceiling well above the roughly five hundred cycles the sequence needs
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // register port: one-cycle strobes, read data in the following cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    req <= {a, d, 1'b1, 1'b0};
    @(posedge ref_clk_i);
    req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    req <= {a, 8'h00, 1'b0, 1'b1};
    @(posedge ref_clk_i);
    req <= '0;
    #1 d = rdata;
  endtask
  task automatic rc(input string name, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    check(name, d, e);
  endtask
  // pin is seen high for several samples before it drops
  task automatic fall();
    @(posedge ref_clk_i);
    pin <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    pin <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    pin <= 1'b1;
  endtask
  task automatic set_count(input logic [7:0] h, input logic [7:0] l);
    wr(timer_two_pkg::ADDR_COUNT_HIGH, h);
    wr(timer_two_pkg::ADDR_COUNT_LOW, l);
  endtask
  task automatic set_reload(input logic [7:0] h, input logic [7:0] l);
    wr(timer_two_pkg::ADDR_RELOAD_HIGH, h);
    wr(timer_two_pkg::ADDR_RELOAD_LOW, l);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    // reset contents of all six places and an unmapped one
    for (int i = 0; i < 6; i++) begin
      rc("reset value", 8'hC8 + i[7:0], 8'h00);
    end
    rc("unmapped", 8'h00, 8'h00);
    wr(timer_two_pkg::ADDR_MODE, 8'hFF);
    rc("mode reg", timer_two_pkg::ADDR_MODE, 8'h01);
    wr(timer_two_pkg::ADDR_MODE, 8'h00);
    // up count wraps from all ones into the reload value
    set_count(8'hFF, 8'hFC);
    set_reload(8'h12, 8'h34);
    wr(timer_two_pkg::ADDR_CONTROL, 8'h04);
    repeat (20) @(posedge ref_clk_i);
    rc("reload high", timer_two_pkg::ADDR_COUNT_HIGH, 8'h12);
    rc("ovf set", timer_two_pkg::ADDR_CONTROL, 8'h84);
    check("ovf out", {6'h00, ovf_flag, irq}, 8'h03);
    // software owns the overflow flag, stopped counter holds
    wr(timer_two_pkg::ADDR_CONTROL, 8'h00);
    rc("ovf cleared", timer_two_pkg::ADDR_CONTROL, 8'h00);
    rd(timer_two_pkg::ADDR_COUNT_LOW, keep);
    repeat (10) @(posedge ref_clk_i);
    rc("halted count", timer_two_pkg::ADDR_COUNT_LOW, keep);
    wr(timer_two_pkg::ADDR_CONTROL, 8'h80);
    rc("ovf by sw", timer_two_pkg::ADDR_CONTROL, 8'h80);
    // capture mode with external enable off ignores the pin
    set_count(8'h56, 8'h00);
    set_reload(8'hAA, 8'hAA);
    wr(timer_two_pkg::ADDR_CONTROL, 8'h05);
    fall();
    rc("pin ignored", timer_two_pkg::ADDR_RELOAD_HIGH, 8'hAA);
    rc("no ext flag", timer_two_pkg::ADDR_CONTROL, 8'h05);
    // with external enable a falling edge captures and flags
    wr(timer_two_pkg::ADDR_CONTROL, 8'h0D);
    fall();
    rc("ext flag", timer_two_pkg::ADDR_CONTROL, 8'h4D);
    check("ext out", {6'h00, ext_flag, irq}, 8'h03);
    wr(timer_two_pkg::ADDR_CONTROL, 8'h00);
    rc("capture high", timer_two_pkg::ADDR_RELOAD_HIGH, 8'h56);
    // reload mode with external enable: a falling edge reloads the count
    set_reload(8'hAB, 8'hCD);
    wr(timer_two_pkg::ADDR_CONTROL, 8'h08);
    fall();
    rc("pin reload", timer_two_pkg::ADDR_COUNT_HIGH, 8'hAB);
    rc("pin reload flag", timer_two_pkg::ADDR_CONTROL, 8'h48);
    wr(timer_two_pkg::ADDR_CONTROL, 8'h00);
    // down count: match with reload loads all ones and flags
    wr(timer_two_pkg::ADDR_MODE, 8'h01);
    set_count(8'hFF, 8'hF8);
    set_reload(8'hFF, 8'hF0);
    wr(timer_two_pkg::ADDR_CONTROL, 8'h04);
    repeat (20) @(posedge ref_clk_i);
    rc("down flags", timer_two_pkg::ADDR_CONTROL, 8'hC4);
    rc("down high", timer_two_pkg::ADDR_COUNT_HIGH, 8'hFF);
    // pin low with down enable set: the same setup counts up
    wr(timer_two_pkg::ADDR_CONTROL, 8'h00);
    pin <= 1'b0;
    set_count(8'h00, 8'h10);
    wr(timer_two_pkg::ADDR_CONTROL, 8'h04);
    repeat (10) @(posedge ref_clk_i);
    wr(timer_two_pkg::ADDR_CONTROL, 8'h00);
    pin <= 1'b1;
    rd(timer_two_pkg::ADDR_COUNT_LOW, keep);
    check("pin low up", {7'h00, keep > 8'h10}, 8'h01);
    wr(timer_two_pkg::ADDR_MODE, 8'h00);
    // baud mode: reload each overflow, one count per 2 clocks, no flag
    set_count(8'hFF, 8'hF0);
    clr <= 1'b1;
    wr(timer_two_pkg::ADDR_CONTROL, 8'h35);
    clr <= 1'b0;
    repeat (200) @(posedge ref_clk_i);
    rc("baud no ovf", timer_two_pkg::ADDR_CONTROL, 8'h35);
    check("baud rx rate", {7'h00, rx_n >= 16'd6 && rx_n <= 16'd7}, 8'h01);
    check("baud tx rate", {7'h00, tx_n >= 16'd6 && tx_n <= 16'd7}, 8'h01);
    // selects clear: other timer's overflow feeds both ticks
    wr(timer_two_pkg::ADDR_CONTROL, 8'h00);
    clr <= 1'b1;
    @(posedge ref_clk_i);
    clr <= 1'b0;
    repeat (80) @(posedge ref_clk_i);
    #1;
    check("t1 rx", {7'h00, rx_n >= 16'd9 && rx_n <= 16'd11}, 8'h01);
    check("t1 tx", {7'h00, tx_n >= 16'd9 && tx_n <= 16'd11}, 8'h01);
    // counter mode counts events only
    set_count(8'h00, 8'h10);
    wr(timer_two_pkg::ADDR_CONTROL, 8'h06);
    repeat (5) begin
      @(posedge ref_clk_i);
      evt <= 1'b1;
      @(posedge ref_clk_i);
      evt <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
    end
    // enable held low: this event must be lost
    cen <= 1'b0;
    evt <= 1'b1;
    @(posedge ref_clk_i);
    cen <= 1'b1;
    evt <= 1'b0;
    wr(timer_two_pkg::ADDR_CONTROL, 8'h00);
    rc("event count", timer_two_pkg::ADDR_COUNT_LOW, 8'h15);
    close_out();
  end
endmodule
`default_nettype wire
